// File: esp_counter.sv
// Notes on behaviour
// R01: Implicit separation: count ticks gate-to-aux, push count, restart on next gate.
// R02: Sampled separation: push completed count only on a sample edge, then await gate.
// R03: Hardware-timed single point behaves exactly as sampled separation.
// R04: Sample edge without a completed gate-and-aux interval raises overrun.
// R05: An outside DMA engine drains the measurement FIFO.
// R06: Single pulse: delay ticks after arming, then a pulse of width ticks.
// R07: Triggered single pulse: first gate trigger starts it, later gate ignored.
// R08: Finite train: embedded count of pulses stops the train at the total.
// R09: Legacy finite train: no embedded count, partner gating pulse bounds the train.
// R10: Retriggerable: gate ignored while generating, then wait for next trigger.
// R11: Config bit picks initial delay on every retrigger or first only.
// R12: No pause trigger while gate serves as start trigger.
// R13: Source keeps two ticks between a trigger and the first used tick; the code counts the first source tick after the trigger cycle.
// R14: Continuous train: delay, then alternating high and low widths.
// R15: Gate as pause trigger freezes generation while pause is active.
// R16: Continuous period equals high plus low ticks.
// R17: Sampled buffered generation takes a new spec at the sample edge; the code loads it at the end of the first high phase after that edge.
// R18: Implicit buffered ignores initial settings; sampled plays them until first sample.
// R19: Implicit buffered: one pulse per entry, back to back.
// R20: Finite implicit buffered: pulse count equals pairs total, then stop.
// R21: Continuous buffered generation runs until disarmed.
// R22: A running interval ignores further start edges until it ends.
// R23: Overrun stays set until cleared or disarmed.
// R24: Empty spec buffer keeps the last idle and active widths.
`timescale 1ns/1ns
`default_nettype none

module esp_counter
	import esp_pkg::*;
(
	input  wire logic                 clk_sys_in,
	input  wire logic                 arst_n_in,
	input  wire logic                 arm_in,
	input  wire esp_mode_t            mode_in,
	input  wire esp_edge_sel_t        edge_sel_in,
	input  wire esp_ctrl_t            ctrl_in,
	input  wire esp_timing_t          timing_in,
	input  wire logic                 source_in,
	input  wire logic                 gate_in,
	input  wire logic                 aux_in,
	input  wire logic                 sample_clk_in,
	input  wire logic                 pair_gate_in,
	input  wire logic                 overrun_clr_in,
	output logic                      overrun_out,
	output logic [ESP_CNT_W-1:0]      meas_data_out,
	output logic                      meas_valid_out,
	input  wire logic                 meas_ready_in,
	input  wire esp_spec_t            spec_in,
	input  wire logic                 spec_valid_in,
	output logic                      spec_ready_out,
	output logic                      pulse_out,
	output logic                      busy_out,
	output logic                      done_out
);
	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [ESP_PINS-1:0] sync1_reg;
	logic [ESP_PINS-1:0] sync2_reg;
	logic [ESP_PINS-1:0] sync3_reg;
	logic [ESP_PINS-1:0] level_reg;
	logic [ESP_PINS-1:0] level_next;
	logic [ESP_PINS-1:0] pol;
	logic [ESP_PINS-1:0] act;

	assign pol = {edge_sel_in.sample_rising, edge_sel_in.aux_rising,
	              edge_sel_in.gate_rising, edge_sel_in.src_rising};

	// A level change is accepted once stages two and three agree
	always_comb begin
		for (int i = 0; i < ESP_PINS; i++) begin
			level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : level_reg[i];
			act[i]        = (level_next[i] != level_reg[i]) && (level_next[i] == pol[i]);
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
		end else begin
			sync1_reg <= {sample_clk_in, aux_in, gate_in, source_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	logic src_act;
	logic gate_act;
	logic aux_act;
	logic smp_act;

	assign src_act  = act[ESP_PIN_SRC];
	assign gate_act = act[ESP_PIN_GATE];
	assign aux_act  = act[ESP_PIN_AUX];
	assign smp_act  = act[ESP_PIN_SMP];

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	logic is_sep;
	logic sep_sampled;
	logic is_gen;
	logic buf_impl;
	logic buf_smp;
	logic legacy_fin;
	logic legacy_stop;
	logic trig_mode;
	logic paused;
	logic tick;

	assign sep_sampled = (mode_in == ESP_MD_SEP_SAMPLED)
	                  || (mode_in == ESP_MD_HW_TIMED_SINGLE_POINT); // R03
	assign is_sep      = sep_sampled || (mode_in == ESP_MD_SEP_IMPLICIT);
	assign buf_impl    = (mode_in == ESP_MD_GEN_BUF_IMPLICIT);
	assign buf_smp     = (mode_in == ESP_MD_GEN_BUF_SAMPLED);
	assign is_gen      = !is_sep;
	assign legacy_fin  = (mode_in == ESP_MD_PULSE_FINITE) && ctrl_in.legacy_pair;
	assign legacy_stop = legacy_fin && !pair_gate_in; // R09
	// Retriggering always consumes the gate as start trigger
	assign trig_mode   = ctrl_in.start_trig_en || ctrl_in.retrigger_en;
	// Pause needs the gate free, so any start-trigger use disables it
	assign paused      = ctrl_in.pause_en && !trig_mode
	                  && (level_reg[ESP_PIN_GATE] == ctrl_in.pause_active_high); // R12 R15
	assign tick        = src_act && !paused; // R15

	// ------------------------------------------------------------------
	// Edge-separation measurement
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {M_OFF, M_WAIT_GATE, M_COUNT, M_HOLD, M_PUSH} esp_meas_st_t;

	esp_meas_st_t         mst_reg;
	logic [ESP_CNT_W-1:0] mcnt_reg;
	logic [ESP_CNT_W-1:0] res_reg;
	logic                 push_ready;
	logic                 ov_set;

	// Edges arriving while a result waits for the buffer are not seen;
	// the two-entry buffer keeps that window short under normal draining
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mst_reg  <= M_OFF;
			mcnt_reg <= '0;
			res_reg  <= '0;
		end else if (!arm_in || !is_sep) begin
			mst_reg <= M_OFF;
		end else begin
			unique case (mst_reg)
				M_OFF: begin
					mst_reg <= M_WAIT_GATE;
				end
				M_WAIT_GATE: begin
					if (gate_act) begin // R01
						mcnt_reg <= '0;
						mst_reg  <= M_COUNT;
					end
				end
				M_COUNT: begin
					// Further gate edges are ignored here
					mcnt_reg <= mcnt_reg + ESP_CNT_W'(src_act); // R22
					if (aux_act) begin
						res_reg <= mcnt_reg + ESP_CNT_W'(src_act); // R01
						mst_reg <= sep_sampled ? M_HOLD : M_PUSH; // R02
					end
				end
				M_HOLD: begin
					if (smp_act) begin // R02
						mst_reg <= M_PUSH;
					end
				end
				M_PUSH: begin
					if (push_ready) begin // R01 R02
						mst_reg <= M_WAIT_GATE;
					end
				end
			endcase
		end
	end

	// A sample edge finds no completed interval, or the previous one stuck
	assign ov_set = arm_in && is_sep && sep_sampled && smp_act
	             && (mst_reg == M_WAIT_GATE || mst_reg == M_COUNT || mst_reg == M_PUSH); // R04

	// Sticky error; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			overrun_out <= 1'b0;
		end else if (ov_set) begin
			overrun_out <= 1'b1; // R04
		end else if (overrun_clr_in || !arm_in) begin
			overrun_out <= 1'b0; // R23
		end
	end

	// Results are drained by the outside transfer engine
	esp_buf #(
		.WIDTH (ESP_CNT_W),
		.DEPTH (ESP_BUF_DEPTH)
	) u_meas_buf (
		.clk_sys_in    (clk_sys_in),
		.arst_n_in     (arst_n_in),
		.in_data_in    (res_reg),
		.in_valid_in   (mst_reg == M_PUSH),
		.in_ready_out  (push_ready),
		.out_data_out  (meas_data_out),
		.out_valid_out (meas_valid_out),
		.out_ready_in  (meas_ready_in) // R05
	);

	// ------------------------------------------------------------------
	// Pulse generation
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {G_OFF, G_TRIG, G_DELAY, G_LOW, G_HIGH, G_DONE} esp_gen_st_t;

	esp_gen_st_t          gst_reg;
	logic [ESP_CNT_W-1:0] gcnt_reg;
	logic [ESP_CNT_W-1:0] cur_low_reg;
	logic [ESP_CNT_W-1:0] cur_high_reg;
	logic [ESP_CNT_W-1:0] npulse_reg;
	logic [ESP_CNT_W-1:0] npulse_inc;
	logic                 first_done_reg;
	logic                 smp_pend_reg;
	logic                 use_delay;
	logic                 start_ok;
	logic                 phase_end;
	logic                 fin_reached;
	logic                 fin_end_buf;
	logic                 pop_start;
	logic                 pop_next;
	esp_spec_t            spec_head;
	logic                 spec_avail;

	// Zero widths would never end a phase, so they act as one tick
	function automatic logic [ESP_CNT_W-1:0] esp_clamp(input logic [ESP_CNT_W-1:0] w);
		return (w == '0) ? ESP_CNT_W'(1) : w;
	endfunction

	assign npulse_inc  = npulse_reg + 1'b1;
	assign use_delay   = (timing_in.delay_ticks != '0)
	                  && (!first_done_reg || ctrl_in.initial_delay_each_retrigger); // R11
	assign start_ok    = (!trig_mode || gate_act) && (!buf_impl || spec_avail)
	                  && (!legacy_fin || pair_gate_in); // R07 R10 R14
	assign phase_end   = tick && (gcnt_reg == ESP_CNT_W'(1));
	assign fin_reached = (npulse_inc >= timing_in.total_pulses);
	assign fin_end_buf = buf_impl && ctrl_in.buf_finite && fin_reached; // R20
	assign pop_start   = (gst_reg == G_TRIG) && start_ok && buf_impl && arm_in;
	assign pop_next    = (gst_reg == G_HIGH) && phase_end && !legacy_stop && arm_in
	                  && spec_avail && !fin_end_buf
	                  && (buf_impl || (buf_smp && smp_pend_reg)); // R17 R19

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gst_reg        <= G_OFF;
			gcnt_reg       <= '0;
			cur_low_reg    <= '0;
			cur_high_reg   <= '0;
			npulse_reg     <= '0;
			first_done_reg <= 1'b0;
		end else if (!arm_in || !is_gen) begin
			gst_reg        <= G_OFF; // R21
			first_done_reg <= 1'b0;
		end else begin
			if (tick && gcnt_reg > ESP_CNT_W'(1)) begin
				gcnt_reg <= gcnt_reg - 1'b1; // R15
			end
			unique case (gst_reg)
				G_OFF: begin
					gst_reg <= G_TRIG;
				end
				G_TRIG: begin
					// Gate edges count only here, never during a pulse
					if (start_ok) begin // R07 R10
						first_done_reg <= 1'b1;
						npulse_reg     <= '0;
						if (buf_impl) begin
							cur_low_reg  <= spec_head.idle_ticks; // R18
							cur_high_reg <= spec_head.active_ticks;
							gcnt_reg     <= esp_clamp(spec_head.idle_ticks);
							gst_reg      <= G_LOW;
						end else begin
							cur_low_reg  <= timing_in.low_ticks; // R18
							cur_high_reg <= timing_in.high_ticks;
							if (use_delay) begin // R06 R11 R14
								gcnt_reg <= timing_in.delay_ticks;
								gst_reg  <= G_DELAY;
							end else if (buf_smp) begin
								gcnt_reg <= esp_clamp(timing_in.low_ticks);
								gst_reg  <= G_LOW;
							end else begin
								gcnt_reg <= esp_clamp(timing_in.high_ticks);
								gst_reg  <= G_HIGH;
							end
						end
					end
				end
				G_DELAY: begin
					if (legacy_stop) begin
						gst_reg <= G_DONE; // R09
					end else if (phase_end) begin // R06
						gcnt_reg <= buf_smp ? esp_clamp(cur_low_reg) : esp_clamp(cur_high_reg);
						gst_reg  <= buf_smp ? G_LOW : G_HIGH;
					end
				end
				G_LOW: begin
					if (legacy_stop) begin
						gst_reg <= G_DONE; // R09
					end else if (phase_end) begin
						gcnt_reg <= esp_clamp(cur_high_reg); // R14 R16
						gst_reg  <= G_HIGH;
					end
				end
				G_HIGH: begin
					if (legacy_stop) begin
						gst_reg <= G_DONE; // R09
					end else if (phase_end) begin
						npulse_reg <= npulse_inc; // R08
						unique case (mode_in)
							ESP_MD_PULSE_SINGLE: begin
								gst_reg <= ctrl_in.retrigger_en ? G_TRIG : G_DONE; // R06 R10
							end
							ESP_MD_PULSE_FINITE: begin
								if (fin_reached && !legacy_fin) begin // R08
									gst_reg <= ctrl_in.retrigger_en ? G_TRIG : G_DONE; // R10
								end else begin
									gcnt_reg <= esp_clamp(cur_low_reg);
									gst_reg  <= G_LOW;
								end
							end
							ESP_MD_GEN_BUF_IMPLICIT, ESP_MD_GEN_BUF_SAMPLED: begin
								if (fin_end_buf) begin
									gst_reg <= G_DONE; // R20
								end else if (pop_next) begin
									cur_low_reg  <= spec_head.idle_ticks; // R17 R19
									cur_high_reg <= spec_head.active_ticks;
									gcnt_reg     <= esp_clamp(spec_head.idle_ticks);
									gst_reg      <= G_LOW;
								end else begin
									gcnt_reg <= esp_clamp(cur_low_reg); // R24
									gst_reg  <= G_LOW;
								end
							end
							default: begin
								gcnt_reg <= esp_clamp(cur_low_reg); // R14 R16
								gst_reg  <= G_LOW;
							end
						endcase
					end
				end
				G_DONE: begin
					gst_reg <= G_DONE;
				end
			endcase
		end
	end

	// Sample edge latches an update for the next pulse boundary
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			smp_pend_reg <= 1'b0;
		end else if (!arm_in || !buf_smp) begin
			smp_pend_reg <= 1'b0;
		end else if (smp_act && gst_reg != G_OFF && gst_reg != G_TRIG) begin
			smp_pend_reg <= 1'b1; // R17
		end else if (pop_next) begin
			smp_pend_reg <= 1'b0;
		end
	end

	// Output pin; the legacy partner pulse gates it as well
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pulse_out <= 1'b0;
		end else begin
			pulse_out <= arm_in && (gst_reg == G_HIGH) && !legacy_stop; // R06 R09
		end
	end

	assign busy_out = (gst_reg == G_DELAY) || (gst_reg == G_LOW) || (gst_reg == G_HIGH);
	assign done_out = (gst_reg == G_DONE);

	esp_buf #(
		.WIDTH ($bits(esp_spec_t)),
		.DEPTH (ESP_BUF_DEPTH)
	) u_spec_buf (
		.clk_sys_in    (clk_sys_in),
		.arst_n_in     (arst_n_in),
		.in_data_in    (spec_in),
		.in_valid_in   (spec_valid_in),
		.in_ready_out  (spec_ready_out),
		.out_data_out  (spec_head),
		.out_valid_out (spec_avail),
		.out_ready_in  (pop_start || pop_next)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	property p_implicit_result;
		(arm_in && mode_in == ESP_MD_SEP_IMPLICIT && mst_reg == M_COUNT && aux_act)
		|=> (mst_reg == M_PUSH) && (res_reg == $past(mcnt_reg) + ESP_CNT_W'($past(src_act)));
	endproperty
	a_implicit_result: assert property (p_implicit_result) else $error("bad implicit result"); // R01

	property p_sampled_push;
		(arm_in && mode_in == ESP_MD_SEP_SAMPLED && mst_reg == M_HOLD)
		|-> ##1 ((mst_reg == M_PUSH) == $past(smp_act && arm_in && is_sep));
	endproperty
	a_sampled_push: assert property (p_sampled_push) else $error("sampled push timing"); // R02

	property p_hw_timed_single_point_hold;
		(arm_in && mode_in == ESP_MD_HW_TIMED_SINGLE_POINT && mst_reg == M_COUNT && aux_act)
		|=> mst_reg == M_HOLD;
	endproperty
	a_hw_timed_single_point_hold: assert property (p_hw_timed_single_point_hold) else $error("hw timed not held"); // R03

	property p_overrun;
		(arm_in && sep_sampled && smp_act && mst_reg == M_COUNT) |=> overrun_out;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not raised"); // R04

	property p_overrun_sticky;
		(overrun_out && arm_in && !overrun_clr_in) |=> overrun_out;
	endproperty
	a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun lost"); // R23

	property p_gate_ignored;
		(arm_in && is_sep && mst_reg == M_COUNT && gate_act && !aux_act) |=> mst_reg == M_COUNT;
	endproperty
	a_gate_ignored: assert property (p_gate_ignored) else $error("interval restarted"); // R22

	property p_single_end;
		(arm_in && mode_in == ESP_MD_PULSE_SINGLE && gst_reg == G_HIGH && phase_end)
		|=> (gst_reg == ($past(ctrl_in.retrigger_en) ? G_TRIG : G_DONE)) ##1 !pulse_out;
	endproperty
	a_single_end: assert property (p_single_end) else $error("single pulse end"); // R06 R10

	property p_finite_stop;
		(arm_in && mode_in == ESP_MD_PULSE_FINITE && !legacy_fin && gst_reg == G_HIGH
		 && phase_end && fin_reached && !ctrl_in.retrigger_en) |=> gst_reg == G_DONE;
	endproperty
	a_finite_stop: assert property (p_finite_stop) else $error("finite train ran on"); // R08

	property p_pause_freeze;
		(arm_in && is_gen && paused && busy_out && !legacy_stop)
		|=> $stable(gcnt_reg) && $stable(gst_reg);
	endproperty
	a_pause_freeze: assert property (p_pause_freeze) else $error("pause not honoured"); // R15

	property p_high_to_pulse;
		(arm_in && gst_reg == G_HIGH && !legacy_stop) |=> pulse_out;
	endproperty
	a_high_to_pulse: assert property (p_high_to_pulse) else $error("pulse missing"); // R14
endmodule

`default_nettype wire

// File: esp_far.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Timebase source and DMA drain facing the counter
// ----------------------------------------------------------------------
module esp_far
	import esp_pkg::*;
(
	input  wire logic                 clk_sys_in,
	input  wire logic                 arst_n_in,
	input  wire logic                 stall_in,
	input  wire logic [ESP_CNT_W-1:0] meas_data_in,
	input  wire logic                 meas_valid_in,
	output logic                      meas_ready_out,
	output logic                      source_out,
	output logic [7:0]                n_words_out
);
	logic [2:0]           div_reg;
	logic [ESP_CNT_W-1:0] words [4];

	// Free-running timebase, one tick per 8 clocks so pin edges never merge
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_reg <= 3'h0;
			source_out <= 1'b0;
		end else begin
			div_reg <= div_reg + 3'h1;
			source_out <= div_reg[2];
		end
	end

	// Drain holds back while stalled, to prove the buffer keeps words
	assign meas_ready_out = !stall_in;
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			n_words_out <= 8'h00;
		end else if (meas_valid_in && meas_ready_out) begin
			words[n_words_out[1:0]] <= meas_data_in;
			n_words_out <= n_words_out + 8'h01;
		end
	end
endmodule

`default_nettype wire

// File: esp_pkg_buf.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Shared constants and carriers
// ----------------------------------------------------------------------
package esp_pkg;
	localparam int ESP_CNT_W     = 32;
	localparam int ESP_BUF_DEPTH = 2;
	localparam int ESP_PINS      = 4;
	localparam int ESP_PIN_SRC   = 0;
	localparam int ESP_PIN_GATE  = 1;
	localparam int ESP_PIN_AUX   = 2;
	localparam int ESP_PIN_SMP   = 3;

	typedef enum logic [2:0] {
		ESP_MD_SEP_IMPLICIT,
		ESP_MD_SEP_SAMPLED,
		ESP_MD_HW_TIMED_SINGLE_POINT,
		ESP_MD_PULSE_SINGLE,
		ESP_MD_PULSE_FINITE,
		ESP_MD_PULSE_CONT,
		ESP_MD_GEN_BUF_IMPLICIT,
		ESP_MD_GEN_BUF_SAMPLED
	} esp_mode_t;

	// Polarity of each pin's active edge, 1 = rising
	typedef struct packed {
		logic src_rising;
		logic gate_rising;
		logic aux_rising;
		logic sample_rising;
	} esp_edge_sel_t;

	typedef struct packed {
		logic start_trig_en;
		logic pause_en;
		logic pause_active_high;
		logic retrigger_en;
		logic initial_delay_each_retrigger;
		logic buf_finite;
		logic legacy_pair;
	} esp_ctrl_t;

	typedef struct packed {
		logic [ESP_CNT_W-1:0] delay_ticks;
		logic [ESP_CNT_W-1:0] high_ticks;
		logic [ESP_CNT_W-1:0] low_ticks;
		logic [ESP_CNT_W-1:0] total_pulses;
	} esp_timing_t;

	// One buffered pulse: idle phase first, then active phase
	typedef struct packed {
		logic [ESP_CNT_W-1:0] idle_ticks;
		logic [ESP_CNT_W-1:0] active_ticks;
	} esp_spec_t;
endpackage

// ----------------------------------------------------------------------
// Small FIFO with valid/ready on both sides
// ----------------------------------------------------------------------
module esp_buf
	import esp_pkg::*;
#(
	parameter int WIDTH = ESP_CNT_W,
	parameter int DEPTH = ESP_BUF_DEPTH
) (
	input  wire logic             clk_sys_in,
	input  wire logic             arst_n_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic [WIDTH-1:0]      out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// Pointers wrap by overflow, so the depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("esp_buf depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] fill_reg;
	logic             push;
	logic             pop;

	assign in_ready_out  = (fill_reg != CNT_W'(DEPTH));
	assign out_valid_out = (fill_reg != '0);
	assign out_data_out  = mem_reg[rd_ptr_reg];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage needs no reset; only the pointers and fill level say what is valid
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg   <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				fill_reg <= fill_reg + 1'b1;
			end else if (pop && !push) begin
				fill_reg <= fill_reg - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------
module testbench
	import esp_pkg::*;
;
	logic        clk_sys_in, arst_n_in, arm, oclr, stall, sv, sr, pls, busy, done, ovr, mv, mr;
	logic        src, pq, mclr;
	logic [3:0]  pin;
	logic [31:0] md_q;
	logic [7:0]  nw, b;
	esp_mode_t   md;
	esp_ctrl_t   ct;
	esp_timing_t tm;
	esp_spec_t   sp;
	int          n_errors, n_checks, nrise, sumhi, hicnt, lasthi, percnt, lastper;

	esp_counter dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .arm_in(arm),
		.mode_in(md), .edge_sel_in(4'hf), .ctrl_in(ct), .timing_in(tm), .source_in(src),
		.gate_in(pin[ESP_PIN_GATE]), .aux_in(pin[ESP_PIN_AUX]), .sample_clk_in(pin[ESP_PIN_SMP]),
		.pair_gate_in(1'b0), .overrun_clr_in(oclr), .overrun_out(ovr), .meas_data_out(md_q),
		.meas_valid_out(mv), .meas_ready_in(mr), .spec_in(sp), .spec_valid_in(sv),
		.spec_ready_out(sr), .pulse_out(pls), .busy_out(busy), .done_out(done));
	esp_far far (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .stall_in(stall),
		.meas_data_in(md_q), .meas_valid_in(mv), .meas_ready_out(mr), .source_out(src),
		.n_words_out(nw));

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// Pulse monitor: rises, high time, last high width and last period in clocks
	always @(posedge clk_sys_in) begin
		pq <= pls;
		hicnt <= pls ? hicnt + 1 : 0;
		percnt <= (pls && !pq) ? 1 : percnt + 1;
		if (pls && !pq) lastper <= percnt;
		if (!pls && pq) lasthi <= hicnt;
		if (mclr) begin
			nrise <= 0;
			sumhi <= 0;
		end else begin
			if (pls) sumhi <= sumhi + 1;
			if (pls && !pq) nrise <= nrise + 1;
		end
	end

	task automatic conclude;
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Bounded wait for done (w=0) or for n drained words (w=1)
	task automatic wait_for(input int w, input logic [7:0] n);
		int t;
		for (t = 0; t < 1000 && !(w == 0 ? done === 1'b1 : nw >= n); t++) cyc(1);
		if (t >= 1000) begin
			check(32'h0, 32'h1);
			conclude();
		end
	endtask
	task automatic ticks(input int k);
		logic p;
		p = src;
		for (int t = 0; k > 0; t++) begin
			@(posedge clk_sys_in);
			if (src && !p) k--;
			p = src;
			if (t > 400) begin
				check(32'h0, 32'h1);
				conclude();
			end
		end
	endtask
	// Pin pulse mid-phase of the timebase, well clear of its edges
	task automatic pulse(input int i);
		cyc(2);
		pin[i] <= 1'b1;
		cyc(3);
		pin[i] <= 1'b0;
	endtask
	task automatic sep(input int k, input bit x);
		ticks(1);
		pulse(ESP_PIN_GATE);
		if (x) begin
			ticks(1);
			pulse(ESP_PIN_GATE);
			k--;
		end
		ticks(k);
		pulse(ESP_PIN_AUX);
	endtask
	task automatic setup(input esp_mode_t m, input esp_ctrl_t c, input esp_timing_t t);
		arm <= 1'b0;
		mclr <= 1'b1;
		cyc(4);
		md <= m;
		ct <= c;
		tm <= t;
		b = nw;
		cyc(1);
		mclr <= 1'b0;
		arm <= 1'b1;
	endtask
	task automatic push(input esp_spec_t s, input bit last);
		int t;
		sp <= s;
		sv <= 1'b1;
		for (t = 0; t < 500; t++) begin
			@(posedge clk_sys_in);
			if (sr === 1'b1) break;
		end
		// A buffer that never takes the entry is a hang, counted as a mismatch
		if (t >= 500) begin
			check(32'h0, 32'h1);
			conclude();
		end
		if (last) sv <= 1'b0;
	endtask

	task automatic t_sep;
		setup(ESP_MD_SEP_IMPLICIT, 7'h00, '0);
		stall <= 1'b1;
		sep(3, 0);
		sep(5, 1);
		cyc(10);
		check(nw, b);
		stall <= 1'b0;
		wait_for(1, b + 8'h02);
		check(far.words[b[1:0]], 32'h3);
		check(far.words[b[1:0] + 2'h1], 32'h5);
		$display("test sep done");
	endtask
	task automatic t_smp(input esp_mode_t m);
		setup(m, 7'h00, '0);
		pulse(ESP_PIN_SMP);
		cyc(8);
		check(ovr, 1'b1);
		cyc(30);
		check(ovr, 1'b1);
		oclr <= 1'b1;
		cyc(1);
		oclr <= 1'b0;
		cyc(2);
		check(ovr, 1'b0);
		sep(4, 0);
		cyc(20);
		check(nw, b);
		pulse(ESP_PIN_SMP);
		wait_for(1, b + 8'h01);
		check(far.words[b[1:0]], 32'h4);
		check(ovr, 1'b0);
		$display("test sampled done");
	endtask
	task automatic t_gen;
		setup(ESP_MD_PULSE_SINGLE, 7'h00, {32'h2, 32'h3, 32'h1, 32'h1});
		wait_for(0, 0);
		cyc(2);
		check(nrise, 1);
		check(sumhi, 24);
		// Start trigger on the gate; a second gate pulse during the delay is ignored
		setup(ESP_MD_PULSE_SINGLE, 7'h40, {32'h2, 32'h1, 32'h1, 32'h1});
		cyc(40);
		check(nrise, 0);
		pulse(ESP_PIN_GATE);
		pulse(ESP_PIN_GATE);
		wait_for(0, 0);
		cyc(2);
		check(nrise, 1);
		setup(ESP_MD_PULSE_FINITE, 7'h00, {32'h1, 32'h1, 32'h1, 32'h4});
		wait_for(0, 0);
		cyc(2);
		check(nrise, 4);
		check(sumhi, 32);
		setup(ESP_MD_PULSE_CONT, 7'h00, {32'h1, 32'h2, 32'h3, 32'h0});
		cyc(200);
		check(lastper, 40);
		check(lasthi, 16);
		setup(ESP_MD_GEN_BUF_IMPLICIT, 7'h02, {32'h0, 32'h9, 32'h9, 32'h3});
		push({32'h2, 32'h2}, 0);
		push({32'h3, 32'h4}, 0);
		push({32'h2, 32'h2}, 1);
		wait_for(0, 0);
		cyc(2);
		check(nrise, 3);
		check(sumhi, 64);
		$display("test generation done");
	endtask

	// Main sequence: reset held 8 clocks, then each scenario in turn
	initial begin
		arst_n_in = 1'b0;
		{arm, oclr, stall, sv, mclr, pin} = '0;
		md = ESP_MD_SEP_IMPLICIT;
		ct = '0;
		tm = '0;
		sp = '0;
		cyc(8);
		arst_n_in <= 1'b1;
		cyc(2);
		t_sep();
		t_smp(ESP_MD_SEP_SAMPLED);
		t_smp(ESP_MD_HW_TIMED_SINGLE_POINT);
		t_gen();
		conclude();
	end
endmodule

`default_nettype wire
